// ### core/sra_pkg.sv
`default_nettype none
package sra_pkg;
	// byte and address widths of the serial register space
	localparam int unsigned SRA_BYTE_W = 8;
	localparam int unsigned SRA_ADDR_W = 7;
	localparam int unsigned SRA_REGS = 128;
	localparam int unsigned SRA_CNT_W = 5;
	// rising-edge count values (edges counted from zero)
	localparam logic [4:0] SRA_CNT_ZERO = 5'h00;
	localparam logic [4:0] SRA_CNT_ADDR_LAST = 5'h07;
	localparam logic [4:0] SRA_CNT_DATA_LAST = 5'h0f;
	localparam logic [4:0] SRA_CNT_MAX = 5'h1f;
	localparam logic [4:0] SRA_CNT_ONE = 5'h01;
	// falling edge on which read data is loaded, per mode
	localparam logic [4:0] SRA_CNT_RD4_LOAD = 5'h08;
	localparam logic [4:0] SRA_CNT_RD3_LOAD = 5'h09;
	// position of the direction bit in the shift register before the
	// eighth bit arrives, and its read value
	localparam int unsigned SRA_RW_POS = 6;
	localparam logic SRA_RW_READ = 1'b1;
	// reset values
	localparam logic [7:0] SRA_BYTE_RESET = 8'h00;
	localparam logic [6:0] SRA_ADDR_RESET = 7'h00;
	// synchroniser lanes into the core clock
	localparam int unsigned SRA_SYNC_W = 3;
	localparam int unsigned SRA_LANE_TGL = 0;
	localparam int unsigned SRA_LANE_MODE = 1;
	localparam int unsigned SRA_LANE_SEL = 2;
endpackage : sra_pkg
`default_nettype wire

// ### core/sra_spi_slave.sv
`default_nettype none
module sra_spi_slave
	import sra_pkg::*;
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic SCLK,
	input wire logic CHIP_SELECT_N,
	input wire logic THREE_WIRE,
	input wire logic SDI_IN,
	output logic SDI_OUT,
	output logic SDI_OE_N,
	output logic SDO_OUT,
	output logic SDO_OE_N,
	output logic WR_STROBE,
	output logic [SRA_ADDR_W-1:0] WR_ADDR,
	output logic [SRA_BYTE_W-1:0] WR_DATA,
	output logic SELECTED
);
	// core-domain state
	logic link_rst_q;
	logic [SRA_SYNC_W-1:0] sync_in;
	logic [SRA_SYNC_W-1:0] sync_out;
	logic tgl_seen_q;
	logic wr_event;
	logic wr_strobe_q;
	logic [SRA_ADDR_W-1:0] wr_addr_out_q;
	logic [SRA_BYTE_W-1:0] wr_data_out_q;

	// link-domain state
	logic frame_rst;
	logic [SRA_CNT_W-1:0] cnt_q;
	logic [SRA_CNT_W-1:0] cnt_d;
	logic [SRA_BYTE_W-1:0] sr_q;
	logic [SRA_BYTE_W-1:0] sr_d;
	logic rw_q;
	logic mode_q;
	logic [SRA_ADDR_W-1:0] addr_q;
	logic addr_done;
	logic data_done;
	logic do_write;
	logic [SRA_BYTE_W-1:0] mem [SRA_REGS];
	logic [SRA_ADDR_W-1:0] wr_addr_q;
	logic [SRA_BYTE_W-1:0] wr_data_q;
	logic wr_tgl_q;
	logic load_cnt_hit;
	logic tx_load;
	logic tx_bit;
	logic tx_active;

	// frame phase, one-hot, link domain
	typedef enum logic [3:0] {
		ph_addr = 4'h1,
		ph_turn = 4'h2,
		ph_data = 4'h4,
		ph_done = 4'h8
	} sra_phase_t;
	sra_phase_t phase_q;
	sra_phase_t phase_d;
	logic turn_needed;
	logic in_data;
	logic rd_phase;

	// read drive decode and the mode crossing
	logic rd_drive_4w;
	logic rd_drive_3w;
	logic mode_hold_q;

	// link reset held from the core reset; a constant-only async reset
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			link_rst_q <= 1'b1;
		end else begin
			link_rst_q <= 1'b0;
		end
	end

	// frame reset
	// select high, or core reset, wipes the per-frame state
	assign frame_rst = link_rst_q | CHIP_SELECT_N;

	// counter saturates so long frames cannot wrap into a new address
	assign cnt_d = (cnt_q == SRA_CNT_MAX) ? cnt_q : cnt_q + SRA_CNT_ONE;
	assign sr_d = {sr_q[SRA_BYTE_W-2:0], SDI_IN};
	assign addr_done = (cnt_q == SRA_CNT_ADDR_LAST);
	assign data_done = (cnt_q == SRA_CNT_DATA_LAST);
	// write on sixteenth
	// only the data phase may store; a stray phase blocks the write
	assign do_write = data_done && in_data && (rw_q != SRA_RW_READ);

	// sixteen-clock frame, seventeen for a 3-wire read
	// all link logic runs on the master clock; no edge outside a frame
	always_ff @(posedge SCLK or posedge frame_rst) begin
		if (frame_rst) begin
			cnt_q <= SRA_CNT_ZERO;
			sr_q <= SRA_BYTE_RESET;
		end else begin
			cnt_q <= cnt_d;
			sr_q <= sr_d;
		end
	end

	// mode pin must be static; caught once at frame start
	always_ff @(posedge SCLK or posedge frame_rst) begin
		if (frame_rst) begin
			mode_q <= 1'b0;
		end else if (cnt_q == SRA_CNT_ZERO) begin
			mode_q <= mode_hold_q;
		end
	end

	// address byte first
	// direction and address hold for the rest of the frame
	always_ff @(posedge SCLK or posedge frame_rst) begin
		if (frame_rst) begin
			rw_q <= 1'b0;
			addr_q <= SRA_ADDR_RESET;
		end else if (addr_done) begin
			rw_q <= sr_q[SRA_RW_POS];
			addr_q <= sr_d[SRA_ADDR_W-1:0];
		end
	end

	// turnaround clock
	// only a 3-wire read parks a clock before its data
	assign turn_needed = mode_q && (sr_q[SRA_RW_POS] == SRA_RW_READ);

	// phase walk: address, turnaround if any, data, then idle
	always_comb begin
		phase_d = phase_q;
		unique case (phase_q)
			ph_addr: begin
				if (addr_done) begin
					phase_d = turn_needed ? ph_turn : ph_data;
				end
			end
			ph_turn: begin
				phase_d = ph_data;
			end
			ph_data: begin
				if (data_done) begin
					phase_d = ph_done;
				end
			end
			ph_done: begin
				phase_d = ph_done;
			end
			default: begin
				// stray code: park until select rises
				phase_d = ph_done;
			end
		endcase
	end

	// fresh at select
	// select high restarts the walk at the address byte
	always_ff @(posedge SCLK or posedge frame_rst) begin
		if (frame_rst) begin
			phase_q <= ph_addr;
		end else begin
			phase_q <= phase_d;
		end
	end

	// data phase seen by the write and read paths
	assign in_data = (phase_q == ph_data);

	// register store in the link domain; reads need it within half a clock
	always_ff @(posedge SCLK) begin
		if (do_write) begin
			mem[addr_q] <= sr_d;
		end
	end

	// commit on last
	// a frame cut before the sixteenth edge stores nothing
	always_ff @(posedge SCLK or posedge link_rst_q) begin
		if (link_rst_q) begin
			wr_addr_q <= SRA_ADDR_RESET;
			wr_data_q <= SRA_BYTE_RESET;
		end else if (do_write) begin
			wr_addr_q <= addr_q;
			wr_data_q <= sr_d;
		end
	end

	// toggle flips once per stored write; the core sees its edge
	always_ff @(posedge SCLK or posedge link_rst_q) begin
		if (link_rst_q) begin
			wr_tgl_q <= 1'b0;
		end else if (do_write) begin
			wr_tgl_q <= ~wr_tgl_q;
		end
	end

	// read byte load
	// count and phase must agree before the byte is loaded
	assign rd_phase = in_data && (rw_q == SRA_RW_READ);
	assign load_cnt_hit = mode_q ? (cnt_q == SRA_CNT_RD3_LOAD) :
		(cnt_q == SRA_CNT_RD4_LOAD);
	assign tx_load = load_cnt_hit && rd_phase;

	sra_txshift u_tx (
		.sclk(SCLK),
		.frame_rst(frame_rst),
		.load(tx_load),
		.load_data(mem[addr_q]),
		.bit_out(tx_bit),
		.active(tx_active)
	);

	// shared data line
	// the line is driven from the read byte load until select rises, never while deselected
	assign rd_drive_4w = tx_active & ~mode_q;
	assign rd_drive_3w = tx_active & mode_q;
	assign SDO_OUT = tx_bit;
	assign SDO_OE_N = ~rd_drive_4w;
	assign SDI_OUT = tx_bit;
	assign SDI_OE_N = ~rd_drive_3w;

	// crossings into the core clock: write toggle, mode pin, select
	assign sync_in = {~CHIP_SELECT_N, THREE_WIRE, wr_tgl_q};

	sra_sync #(
		.W(SRA_SYNC_W)
	) u_sync (
		.clk(CLOCK),
		.rst_n(NRST),
		.d(sync_in),
		.q(sync_out)
	);

	// toggle edge marks a completed write; words are stable long before
	assign wr_event = sync_out[SRA_LANE_TGL] ^ tgl_seen_q;

	// toggle history for the write crossing
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			tgl_seen_q <= 1'b0;
		end else begin
			tgl_seen_q <= sync_out[SRA_LANE_TGL];
		end
	end

	// present the write to the core as a one-cycle strobe
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			wr_strobe_q <= 1'b0;
		end else begin
			wr_strobe_q <= wr_event;
		end
	end

	// write words settle long before the toggle gets through
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			wr_addr_out_q <= SRA_ADDR_RESET;
			wr_data_out_q <= SRA_BYTE_RESET;
		end else if (wr_event) begin
			wr_addr_out_q <= wr_addr_q;
			wr_data_out_q <= wr_data_q;
		end
	end

	// mode frozen while selected, so a late pin change cannot split a frame
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			mode_hold_q <= 1'b0;
		end else if (!sync_out[SRA_LANE_SEL]) begin
			mode_hold_q <= sync_out[SRA_LANE_MODE];
		end
	end

	// core-side outputs come straight from flops
	assign WR_STROBE = wr_strobe_q;
	assign WR_ADDR = wr_addr_out_q;
	assign WR_DATA = wr_data_out_q;
	assign SELECTED = sync_out[SRA_LANE_SEL];
endmodule // sra_spi_slave
`default_nettype wire

// ### core/sra_sync.sv
`default_nettype none
module sra_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// two flops; the first one feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule // sra_sync
`default_nettype wire

// ### core/sra_txshift.sv
`default_nettype none
module sra_txshift
	import sra_pkg::*;
(
	input wire logic sclk,
	input wire logic frame_rst,
	input wire logic load,
	input wire logic [SRA_BYTE_W-1:0] load_data,
	output logic bit_out,
	output logic active
);
	logic [SRA_BYTE_W-1:0] tx_q;
	logic [SRA_BYTE_W-1:0] tx_d;
	logic active_q;

	// load once, then shift msb first
	assign tx_d = (load && !active_q) ? load_data :
		{tx_q[SRA_BYTE_W-2:0], 1'b0};

	// output changes only after falling edges; idle outside a frame
	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			tx_q <= SRA_BYTE_RESET;
			active_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			active_q <= active_q | load;
		end
	end

	assign bit_out = tx_q[SRA_BYTE_W-1];
	assign active = active_q;
endmodule // sra_txshift
`default_nettype wire

// ### tb/sra_checker.sv
`default_nettype none
module sra_checker
	import sra_pkg::*;
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic SCLK,
	input wire logic CHIP_SELECT_N,
	input wire logic SDI_OUT,
	input wire logic SDI_OE_N,
	input wire logic SDO_OUT,
	input wire logic SDO_OE_N,
	input wire logic WR_STROBE,
	input wire logic [SRA_ADDR_W-1:0] WR_ADDR,
	input wire logic [SRA_BYTE_W-1:0] WR_DATA,
	input wire logic SELECTED
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	// two high samples mean no falling edge in between
	sequence sclk_high;
		SCLK && $past(SCLK);
	endsequence
	// released outputs and serial output timing
	sdo_release_a: assert property (CHIP_SELECT_N |-> SDO_OE_N)
		else $error("sdo driven while deselected");
	sdi_release_a: assert property (CHIP_SELECT_N |-> SDI_OE_N)
		else $error("sdi driven while deselected");
	oe_hold_a: assert property (!SDO_OE_N |=> !SDO_OE_N || CHIP_SELECT_N)
		else $error("sdo released mid read");
	sdo_edge_a: assert property (sclk_high ##0 !SDO_OE_N |-> $stable(SDO_OUT))
		else $error("sdo moved without falling edge");
	sdi_edge_a: assert property (sclk_high ##0 !SDI_OE_N |-> $stable(SDI_OUT))
		else $error("sdi moved without falling edge");
	// write port and select tracking
	strobe_pulse_a: assert property (WR_STROBE |=> !WR_STROBE)
		else $error("write strobe too long");
	wr_hold_a: assert property (!WR_STROBE |-> $stable({WR_ADDR, WR_DATA}))
		else $error("write port moved without strobe");
	sel_rise_a: assert property ($fell(CHIP_SELECT_N) |-> ##[1:5] SELECTED)
		else $error("select not seen");
endmodule // sra_checker
bind sra_spi_slave sra_checker chk_u (.CLOCK(CLOCK), .NRST(NRST),
	.SCLK(SCLK), .CHIP_SELECT_N(CHIP_SELECT_N), .SDI_OUT(SDI_OUT),
	.SDI_OE_N(SDI_OE_N), .SDO_OUT(SDO_OUT), .SDO_OE_N(SDO_OE_N),
	.WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
	.SELECTED(SELECTED));
`default_nettype wire

// ### tb/sra_master.sv
`default_nettype none
module sra_master (
	output logic SCLK,
	output logic CHIP_SELECT_N,
	output logic SDI_IN,
	input wire logic THREE_WIRE,
	input wire logic SDI_OUT,
	input wire logic SDI_OE_N,
	input wire logic SDO_OUT,
	input wire logic SDO_OE_N
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv = 1'b1;
	logic en = 1'b0;
	logic miso;
	// pulled-up lines read one once released
	assign SDI_IN = !SDI_OE_N ? SDI_OUT : (en ? drv : 1'b1);
	assign miso = THREE_WIRE ? SDI_IN : (SDO_OE_N ? 1'b1 : SDO_OUT);
	initial begin
		SCLK = 1'b0;
		CHIP_SELECT_N = 1'b1;
	end
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [7:0] r);
		CHIP_SELECT_N = 1'b0;
		for (int i = 0; i < n; i++) begin
			drv = (w[15] && i > 7) ? ~drv : w[15-i];
			en = !(w[15] && THREE_WIRE && i > 7);
			#32;
			r = {r[6:0], miso};
			SCLK = 1'b1;
			#32;
			SCLK = 1'b0;
		end
		#32;
		CHIP_SELECT_N = 1'b1;
		en = 1'b0;
		#64;
	endtask
endmodule // sra_master
`default_nettype wire

// ### tb/test_spi_slave_register_access.sv
`default_nettype none
module test_spi_slave_register_access
	import sra_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLOCK = 1'b0;
	logic NRST = 1'b0;
	logic THREE_WIRE = 1'b0;
	wire logic SCLK, CHIP_SELECT_N, SDI_IN, SDI_OUT, SDI_OE_N;
	wire logic SDO_OUT, SDO_OE_N, WR_STROBE, SELECTED;
	wire logic [SRA_ADDR_W-1:0] WR_ADDR;
	wire logic [SRA_BYTE_W-1:0] WR_DATA;
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	int mdl [SRA_REGS];
	logic [14:0] wq [$];
	logic [6:0] aq [$];
	logic [15:0] lf = 16'hd2c8;
	initial forever #5 CLOCK = ~CLOCK;
	sra_spi_slave dut_u (.CLOCK(CLOCK), .NRST(NRST), .SCLK(SCLK),
		.CHIP_SELECT_N(CHIP_SELECT_N), .THREE_WIRE(THREE_WIRE),
		.SDI_IN(SDI_IN), .SDI_OUT(SDI_OUT), .SDI_OE_N(SDI_OE_N),
		.SDO_OUT(SDO_OUT), .SDO_OE_N(SDO_OE_N), .WR_STROBE(WR_STROBE),
		.WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .SELECTED(SELECTED));
	sra_master m_u (.SCLK(SCLK), .CHIP_SELECT_N(CHIP_SELECT_N),
		.SDI_IN(SDI_IN), .THREE_WIRE(THREE_WIRE), .SDI_OUT(SDI_OUT),
		.SDI_OE_N(SDI_OE_N), .SDO_OUT(SDO_OUT), .SDO_OE_N(SDO_OE_N));
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// strobes looked at mid-cycle, clear of the edge that launches them
	// each strobe must match the oldest pending write; hang guard
	always @(negedge CLOCK) begin
		cyc++;
		if (WR_STROBE === 1'b1)
			check({1'b0, WR_ADDR, WR_DATA}, wq.size() ? {1'b0, wq.pop_front()} : 16'hffff);
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end
	// random writes, aborted writes and reads in both modes
	initial begin
		logic [7:0] r;
		logic [6:0] a;
		repeat (20) @(posedge CLOCK);
		#1 NRST = 1'b1;
		for (int k = 0; k < 60; k++) begin
			lf = nxt(lf);
			@(posedge CLOCK);
			#1 THREE_WIRE = lf[0];
			repeat (4) @(posedge CLOCK);
			// select moves just after a core edge, like the mode pin and reset
			#1;
			if (k % 10 == 9) begin
				m_u.xfer({1'b0, lf[14:0]}, 12, r);
			end else if (aq.size() > 0 && lf[1]) begin
				a = aq[lf[10:8] % aq.size()];
				m_u.xfer({1'b1, a, 8'h00}, THREE_WIRE ? 17 : 16, r);
				check({8'h00, r}, mdl[a][15:0]);
			end else begin
				wq.push_back(lf[14:0]);
				mdl[lf[14:8]] = lf[7:0];
				aq.push_back(lf[14:8]);
				m_u.xfer({1'b0, lf[14:0]}, 16, r);
			end
		end
		repeat (10) @(posedge CLOCK);
		check(wq.size(), 16'h0000);
		end_of_test();
	end
endmodule // test_spi_slave_register_access
`default_nettype wire
